// ### rtl/cbc_chan_timer.sv
/*
 * One channel balancing countdown timer.
 * Assumes load and step are one-cycle pulses from the controller.
 */
module cbc_chan_timer
    import cbc_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] load_val,
    input  wire logic             step,
    output logic                  active
);

    logic [TMR_W-1:0] count_r;
    logic [TMR_W-1:0] count_nxt;

    // ************************************************************
    // Countdown
    // ************************************************************
    assign count_nxt = load ? load_val :
                       (step && count_r != '0) ? count_r - 1'b1 : count_r;
    assign active    = (count_r != '0);

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            count_r <= RST_TIMER;
        else
            count_r <= count_nxt;
    end

    step_dec_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (step && !load && count_r != '0) |=> count_r == $past(count_r) - 1'b1)
        else $error("timer did not count down");

endmodule

// ### rtl/cbc_ctrl.sv
/*
 * Cell balance controller top: register file on Avalon-MM, start
 * command, odd/even alternation, selection checks and thermal pause.
 * Assumes die and thermistor comparator inputs are synchronous levels.
 */
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
module cbc_ctrl
    import cbc_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = BAL_UNIT_CYC
)
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              die_hot,
    input  wire logic              die_cool,
    input  wire logic              therm_hot,
    input  wire logic              therm_cool,
    output logic                   die_sense_en,
    output logic [3:0]             thermistor_pause_threshold,
    output logic [2:0]             thermistor_recovery_offset,
    output logic [NUM_CH-1:0]      balance_switch
);

    // ************************************************************
    // Bus handshake and decode
    // ************************************************************
    logic              ack_r;
    logic [31:0]       rdata_r;
    logic [31:0]       rdata_nxt;
    wire               req      = avs_read | avs_write;
    wire               wr_take  = avs_write & ack_r & avs_byteenable[0];
    wire               hit_ctl1 = (avs_address == OFS_CTRL_ONE);
    wire               hit_ctl2 = (avs_address == OFS_CTRL_TWO);
    wire               hit_stat = (avs_address == OFS_STATUS);
    wire               hit_dcf  = (avs_address == OFS_DEVICE_CONFIGURATION);
    wire               hit_tcf  = (avs_address == OFS_THERM_CFG);
    wire [ADDR_W-1:0]  tmr_off  = avs_address - OFS_TIMER0;
    wire               hit_tmr  = (avs_address >= OFS_TIMER0) && (avs_address[1:0] == 2'b00)
                                  && (tmr_off[ADDR_W-1:2] < 4'(NUM_CH));
    wire [2:0]         tmr_idx  = tmr_off[4:2];
    wire               go_pulse = wr_take & hit_ctl2 & avs_writedata[CTL2_GO_BIT];

    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata    = rdata_r;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            ack_r <= 1'b0;
        else
            ack_r <= req & ~ack_r;
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [2:0]       duty_r;
    logic             auto_r;
    logic [3:0]       count_r;
    logic             forbid_r;
    logic [7:0]       therm_cfg_r;
    logic [TMR_W-1:0] tmr_cfg_r [NUM_CH];

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            duty_r      <= RST_DUTY;
            auto_r      <= 1'b0;
            count_r     <= RST_COUNT;
            forbid_r    <= RST_FORBID;
            therm_cfg_r <= RST_THERM;
        end
        else if (wr_take)
        begin
            if (hit_ctl1)
                duty_r <= avs_writedata[2:0];
            if (hit_ctl2)
                auto_r <= avs_writedata[CTL2_AUTO_BIT];
            if (hit_dcf)
            begin
                count_r  <= avs_writedata[DCF_COUNT_LSB +: 4];
                forbid_r <= avs_writedata[DCF_FORBID_BIT];
            end
            if (hit_tcf)
                therm_cfg_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            tmr_cfg_r <= '{default: RST_TIMER};
        else if (wr_take && hit_tmr)
            tmr_cfg_r[tmr_idx] <= avs_writedata[TMR_W-1:0];
    end

    // Thresholds go straight to the protector, which latches them
    assign thermistor_pause_threshold = therm_cfg_r[TCF_THR_LSB +: 4];
    assign thermistor_recovery_offset = therm_cfg_r[TCF_OFS_LSB +: 3];

    // ************************************************************
    // Selection and validity at go
    // ************************************************************
    logic [NUM_CH-1:0] cfg_sel;
    logic [NUM_CH-1:0] act_mask;
    logic              pair_hit;
    logic              triple_hit;

    always_comb
    begin
        pair_hit   = 1'b0;
        triple_hit = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            act_mask[i] = (4'(i) < count_r);
            cfg_sel[i]  = act_mask[i] && (tmr_cfg_r[i] != '0);
        end
        for (int i = 0; i < NUM_CH - 1; i++)
            pair_hit = pair_hit | (cfg_sel[i] & cfg_sel[i+1]);
        for (int i = 0; i < NUM_CH - 2; i++)
            triple_hit = triple_hit | (cfg_sel[i] & cfg_sel[i+1] & cfg_sel[i+2]);
    end

    wire sel_none   = (cfg_sel == '0);
    wire manual_go  = ~avs_writedata[CTL2_AUTO_BIT];
    wire sel_bad    = manual_go & (forbid_r ? pair_hit : triple_hit);
    wire start_ok   = go_pulse & ~sel_none & ~sel_bad;
    wire start_bad  = go_pulse & ~sel_none & sel_bad;

    // ************************************************************
    // Channel timers
    // ************************************************************
    cbc_state_e        state_r;
    cbc_state_e        state_nxt;
    logic [31:0]       unit_cnt_r;
    wire               unit_tick = (state_r == CBC_RUN) && (unit_cnt_r == UNIT_CYCLES - 1);
    logic [NUM_CH-1:0] ch_active;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            cbc_chan_timer u_tmr (
                .core_clk (core_clk),
                .rstn     (rstn),
                .load     (start_ok),
                .load_val (cfg_sel[g] ? tmr_cfg_r[g] : RST_TIMER),
                .step     (unit_tick),
                .active   (ch_active[g])
            );
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            unit_cnt_r <= '0;
        else if (start_ok || unit_tick)
            unit_cnt_r <= '0;
        else if (state_r == CBC_RUN)
            unit_cnt_r <= unit_cnt_r + 1'b1;
    end

    // ************************************************************
    // Sampled run settings
    // ************************************************************
    logic       run_auto_r;
    logic [2:0] run_duty_r;
    logic       run_therm_en_r;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_auto_r     <= 1'b0;
            run_duty_r     <= RST_DUTY;
            run_therm_en_r <= 1'b0;
        end
        else if (start_ok)
        begin
            run_auto_r     <= avs_writedata[CTL2_AUTO_BIT];
            run_duty_r     <= duty_r;
            run_therm_en_r <= therm_cfg_r[TCF_EN_BIT];
        end
    end

    // ************************************************************
    // Run, pause and completion
    // ************************************************************
    logic die_pause_r;
    logic therm_pause_r;
    wire  any_left   = (ch_active != '0);
    wire  die_trip   = die_hot;
    wire  therm_trip = run_therm_en_r & therm_hot;
    wire  pause_go   = (state_r == CBC_RUN) & (die_trip | therm_trip);
    wire  die_clr    = die_pause_r & die_cool;
    wire  therm_clr  = therm_pause_r & therm_cool;
    wire  resume     = (state_r == CBC_PAUSE) & (~die_pause_r | die_clr)
                       & (~therm_pause_r | therm_clr);
    wire  finish     = (state_r == CBC_RUN) & ~any_left & ~start_ok;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CBC_IDLE:
                if (start_ok)
                    state_nxt = CBC_RUN;
            CBC_RUN:
                if (start_ok)
                    state_nxt = CBC_RUN;
                else if (!any_left)
                    state_nxt = CBC_IDLE;
                else if (pause_go)
                    state_nxt = CBC_PAUSE;
            CBC_PAUSE:
                if (start_ok)
                    state_nxt = CBC_RUN;
                else if (resume)
                    state_nxt = CBC_RUN;
            default:
                state_nxt = CBC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r       <= CBC_IDLE;
            die_pause_r   <= 1'b0;
            therm_pause_r <= 1'b0;
        end
        else
        begin
            state_r       <= state_nxt;
            die_pause_r   <= start_ok ? 1'b0 : pause_go ? die_trip : (die_pause_r & ~die_clr);
            therm_pause_r <= start_ok ? 1'b0 : pause_go ? therm_trip :
                             (therm_pause_r & ~therm_clr);
        end
    end

    // Die sensors stay on from go until balancing ends
    logic sense_en_r;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            sense_en_r <= 1'b0;
        else if (go_pulse)
            sense_en_r <= 1'b1;
        else if (state_r == CBC_IDLE)
            sense_en_r <= 1'b0;
    end
    assign die_sense_en = sense_en_r | (state_r != CBC_IDLE);

    // ************************************************************
    // Odd/even alternation
    // ************************************************************
    logic [3:0] phase_cnt_r;
    logic       even_phase_r;
    wire  [NUM_CH-1:0] odd_mask  = 6'h15;
    wire               have_odd  = (ch_active & odd_mask) != '0;
    wire               have_even = (ch_active & ~odd_mask) != '0;
    wire               alternate = run_auto_r & have_odd & have_even;
    wire               phase_end = unit_tick && (phase_cnt_r == {1'b0, run_duty_r});

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_cnt_r  <= '0;
            even_phase_r <= 1'b0;
        end
        else if (start_ok)
        begin
            phase_cnt_r  <= '0;
            even_phase_r <= 1'b0;
        end
        else if (phase_end)
        begin
            phase_cnt_r  <= '0;
            even_phase_r <= ~even_phase_r;
        end
        else if (unit_tick)
            phase_cnt_r <= phase_cnt_r + 1'b1;
    end

    // ************************************************************
    // Switch drive
    // ************************************************************
    logic [NUM_CH-1:0] switch_r;
    wire  [NUM_CH-1:0] grp_mask   = !alternate ? '1 : even_phase_r ? ~odd_mask : odd_mask;
    wire  [NUM_CH-1:0] switch_nxt = (state_nxt == CBC_RUN && !start_ok) ?
                                    (ch_active & act_mask & grp_mask) : '0;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            switch_r <= '0;
        else
            switch_r <= switch_nxt;
    end
    assign balance_switch = switch_r;

    // ************************************************************
    // Status flags
    // ************************************************************
    logic done_r;
    logic bad_r;
    logic therm_flag_r;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            done_r       <= 1'b0;
            bad_r        <= 1'b0;
            therm_flag_r <= 1'b0;
        end
        else
        begin
            done_r       <= finish | (done_r & ~go_pulse);
            bad_r        <= start_bad | (bad_r & ~go_pulse);
            therm_flag_r <= pause_go | (therm_flag_r & ~go_pulse);
        end
    end

    wire [7:0] status_val = {3'h0, therm_flag_r, state_r == CBC_PAUSE, bad_r, done_r,
                             state_r == CBC_RUN};

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (hit_ctl1)
            rdata_nxt[2:0] = duty_r;
        else if (hit_ctl2)
            rdata_nxt[CTL2_AUTO_BIT] = auto_r;
        else if (hit_stat)
            rdata_nxt[7:0] = status_val;
        else if (hit_dcf)
            rdata_nxt[4:0] = {forbid_r, count_r};
        else if (hit_tcf)
            rdata_nxt[7:0] = therm_cfg_r;
        else if (hit_tmr)
            rdata_nxt[TMR_W-1:0] = tmr_cfg_r[tmr_idx];
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_r <= 32'h0000_0000;
        else if (avs_read && !ack_r)
            rdata_r <= rdata_nxt;
    end

    // ************************************************************
    // Checks
    // ************************************************************
    idle_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_r == CBC_IDLE) |-> balance_switch == '0)
        else $error("switch on while idle");

    run_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (balance_switch != '0) |-> status_val[STAT_RUN_BIT])
        else $error("switch on without running flag");

    active_only_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (balance_switch & ~act_mask) == '0)
        else $error("inactive channel switched");

    pause_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_r == CBC_PAUSE) |-> balance_switch == '0)
        else $error("switch on during pause");

    bad_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (start_bad && state_r == CBC_IDLE) |=> (bad_r && state_r == CBC_IDLE)[*2])
        else $error("invalid selection started");

    zero_go_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (go_pulse && sel_none && state_r == CBC_IDLE) |=> !done_r && state_r == CBC_IDLE)
        else $error("zero timers started or completed");

    therm_pause_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (pause_go && !start_ok && any_left) |=> state_r == CBC_PAUSE && therm_flag_r
        && balance_switch == '0)
        else $error("overheat did not pause");

    frozen_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_r == CBC_PAUSE && !start_ok) |=> $stable(unit_cnt_r) && $stable(phase_cnt_r))
        else $error("timers moved in pause");

    manual_on_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_r == CBC_RUN && !run_auto_r && !start_ok && state_nxt == CBC_RUN)
        |=> balance_switch == $past(ch_active & act_mask))
        else $error("manual mode switch mismatch");

endmodule

// ### rtl/cbc_pkg.sv
/*
 * Constants for the cell balance controller: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 40 MHz core clock and a 32-bit Avalon-MM register bus.
 */
package cbc_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_CH   = 6;
    localparam int TMR_W    = 8;
    localparam int ADDR_W   = 6;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE  = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_TWO  = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_DEVICE_CONFIGURATION  = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_THERM_CFG = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_TIMER0    = 6'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTL2_GO_BIT    = 0;
    localparam int CTL2_AUTO_BIT  = 1;
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_BAD_BIT   = 2;
    localparam int STAT_PAUSE_BIT = 3;
    localparam int STAT_THERM_BIT = 4;
    localparam int DCF_COUNT_LSB  = 0;
    localparam int DCF_FORBID_BIT = 4;
    localparam int TCF_THR_LSB    = 0;
    localparam int TCF_OFS_LSB    = 4;
    localparam int TCF_EN_BIT     = 7;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [2:0]       RST_DUTY   = 3'h0;
    localparam logic [3:0]       RST_COUNT  = 4'h6;
    localparam logic             RST_FORBID = 1'b0;
    localparam logic [7:0]       RST_THERM  = 8'h00;
    localparam logic [TMR_W-1:0] RST_TIMER  = 8'h00;

    // ************************************************************
    // Timing: one balancing time unit
    // ************************************************************
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned BAL_UNIT_MS = 1000;
    localparam int unsigned BAL_UNIT_CYC = (CLK_HZ / 1000) * BAL_UNIT_MS;

    // ************************************************************
    // Control states
    // ************************************************************
    typedef enum logic [1:0] {
        CBC_IDLE,
        CBC_RUN,
        CBC_PAUSE
    } cbc_state_e;

endpackage

// ### verification/tb_top.sv
/*
 * Self-checking bench for the cell balance controller.
 * Assumes the one-wait-state Avalon-MM slave and UNIT_CYCLES of 4.
 */
module tb_top
    import cbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic [31:0]       d;
        logic [31:0]       e;
    } cbc_tb_row_s;

    logic              core_clk = 1'b0;
    logic              rstn = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = '0;
    logic [3:0]        avs_byteenable = 4'hF;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              die_hot = 1'b0;
    logic              die_cool = 1'b0;
    logic              therm_hot = 1'b0;
    logic              therm_cool = 1'b0;
    logic              die_sense_en;
    logic [3:0]        thr;
    logic [2:0]        ofs;
    logic [NUM_CH-1:0] sw;
    logic [31:0]       rv;
    int                failures = 0;
    int                check_count = 0;
    cbc_tb_row_s       rows [7] = '{
        '{OFS_CTRL_ONE,  32'h0000_00FD, 32'h0000_0005},
        '{OFS_DEVICE_CONFIGURATION,  32'h0000_00F3, 32'h0000_0013},
        '{OFS_THERM_CFG, 32'h0000_01A5, 32'h0000_00A5},
        '{6'h18,         32'h0000_0137, 32'h0000_0037},
        '{OFS_CTRL_TWO,  32'h0000_0002, 32'h0000_0002},
        '{OFS_STATUS,    32'h0000_001F, 32'h0000_0000},
        '{6'h3C,         32'h0000_00FF, 32'h0000_0000}};

    always #12.5 core_clk = ~core_clk;

    cbc_ctrl #(.UNIT_CYCLES(4)) i_cbc_ctrl (
        .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .die_hot(die_hot), .die_cool(die_cool),
        .therm_hot(therm_hot), .therm_cool(therm_cool), .die_sense_en(die_sense_en),
        .thermistor_pause_threshold(thr), .thermistor_recovery_offset(ofs),
        .balance_switch(sw));

    // ************************************************************
    // Tasks
    // ************************************************************
    task end_sim;
        $display("failures %0d check_count %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            chk(32'h0, 32'h1, "bus timeout");
            end_sim;
        end
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task wait_sw(input logic [NUM_CH-1:0] e, input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (sw !== e && n < lim);
        chk(32'(sw), 32'(e), "switches");
    endtask

    task setup(input logic [47:0] tm, input logic [7:0] dcf, input logic [31:0] c2);
        for (int i = 0; i < NUM_CH; i++)
            bus(1'b1, OFS_TIMER0 + ADDR_W'(4 * i), 32'(tm[8*i+:8]));
        bus(1'b1, OFS_DEVICE_CONFIGURATION, 32'(dcf));
        bus(1'b1, OFS_CTRL_TWO, c2);
    endtask

    // ************************************************************
    // Sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        bus(1'b0, OFS_DEVICE_CONFIGURATION, '0);
        chk(rv, 32'h0000_0006, "count reset");
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, '0);
            chk(rv, rows[i].e, "readback");
        end
        chk(32'({ofs, thr}), 32'h0000_0025, "threshold ports");
        avs_byteenable <= 4'h0;
        bus(1'b1, OFS_TIMER0, 32'h0000_00FF);
        avs_byteenable <= 4'hF;
        bus(1'b0, OFS_TIMER0, '0);
        chk(rv, 32'h0000_0000, "byteenable");
        setup(48'h0000_0000_0205, 8'h06, 32'h0000_0000);
        chk(32'(sw), 32'h0, "no go");
        bus(1'b1, OFS_CTRL_TWO, 32'h0000_0001);
        wait_sw(6'h03, 10);
        bus(1'b0, OFS_STATUS, '0);
        chk(32'({die_sense_en, rv[STAT_RUN_BIT]}), 32'h3, "running");
        wait_sw(6'h01, 40);
        wait_sw(6'h00, 40);
        setup(48'h0000_0000_0303, 8'h01, 32'h0000_0001);
        wait_sw(6'h01, 10);
        wait_sw(6'h00, 40);
        setup(48'h0000_0000_0303, 8'h16, 32'h0000_0001);
        bus(1'b0, OFS_STATUS, '0);
        chk(32'({sw, rv[STAT_BAD_BIT]}), 32'h1, "adjacent");
        setup(48'h0000_0007_0707, 8'h06, 32'h0000_0001);
        bus(1'b0, OFS_STATUS, '0);
        chk(32'({sw, rv[STAT_BAD_BIT]}), 32'h1, "three run");
        setup(48'h0007_0700_0707, 8'h06, 32'h0000_0001);
        wait_sw(6'h1B, 10);
        wait_sw(6'h00, 60);
        setup(48'h0, 8'h06, 32'h0000_0001);
        bus(1'b0, OFS_STATUS, '0);
        chk(32'({sw, rv[1:0]}), 32'h0, "all zero");
        bus(1'b1, OFS_CTRL_ONE, 32'h0000_0000);
        setup(48'h0000_0000_4040, 8'h06, 32'h0000_0003);
        wait_sw(6'h01, 10);
        wait_sw(6'h02, 20);
        setup(48'h0000_0040_0040, 8'h06, 32'h0000_0003);
        wait_sw(6'h05, 10);
        repeat (12) @(posedge core_clk);
        chk(32'(sw), 32'h5, "single group");
        setup(48'h0000_0004_0004, 8'h06, 32'h0000_0001);
        wait_sw(6'h05, 10);
        die_hot <= 1'b1;
        wait_sw(6'h00, 5);
        bus(1'b0, OFS_STATUS, '0);
        chk(32'(rv[4:3]), 32'h3, "die pause");
        die_hot <= 1'b0;
        repeat (40) @(posedge core_clk);
        chk(32'(sw), 32'h0, "still paused");
        die_cool <= 1'b1;
        wait_sw(6'h05, 5);
        die_cool <= 1'b0;
        bus(1'b1, OFS_THERM_CFG, 32'h0000_00A5);
        setup(48'h0000_0004_0004, 8'h06, 32'h0000_0001);
        wait_sw(6'h05, 10);
        therm_hot <= 1'b1;
        wait_sw(6'h00, 5);
        therm_hot <= 1'b0;
        repeat (40) @(posedge core_clk);
        therm_cool <= 1'b1;
        wait_sw(6'h05, 5);
        rstn <= 1'b0;
        @(posedge core_clk);
        @(posedge core_clk);
        chk(32'(sw), 32'h0, "mid reset");
        end_sim;
    end
endmodule
